// ==== shared/rfc_pkg.sv ====
// Shared constants for the receiver configuration bank and its serial controller.
package rfc_pkg;
   // ==========================================================
   // Serial frame layout
   localparam int RFC_ADDR_W = 4;
   localparam int RFC_DATA_W = 32;
   localparam int RFC_HDR_BITS = RFC_ADDR_W + 1;
   localparam int RFC_FRAME_BITS = RFC_HDR_BITS + RFC_DATA_W;
   localparam int RFC_NUM_REGS = 11;
   localparam int RFC_CNT_W = 6;

   // ==========================================================
   // Configuration register indices
   localparam logic [3:0] RFC_IDX_CFG_ONE = 4'h0;
   localparam logic [3:0] RFC_IDX_CFG_TWO = 4'h1;
   localparam logic [3:0] RFC_IDX_CFG_THREE = 4'h2;
   localparam logic [3:0] RFC_IDX_SYNTH_CFG = 4'h3;
   localparam logic [3:0] RFC_IDX_SYNTH_INT = 4'h4;
   localparam logic [3:0] RFC_IDX_SYNTH_FRAC = 4'h5;
   localparam logic [3:0] RFC_IDX_SAMPLE_PORT = 4'h6;
   localparam logic [3:0] RFC_IDX_CLOCKING_ONE = 4'h7;
   localparam logic [3:0] RFC_IDX_TEST_ONE = 4'h8;
   localparam logic [3:0] RFC_IDX_TEST_TWO = 4'h9;
   localparam logic [3:0] RFC_IDX_CLOCKING_TWO = 4'hA;

   // ==========================================================
   // Power-on values, index order
   typedef logic [31:0] rfc_word_t;
   localparam rfc_word_t RFC_RESET [RFC_NUM_REGS] = '{
      32'h80241603, 32'h20550288, 32'h0EAFA1DC, 32'h698C0008,
      32'h00C00080, 32'h08000070, 32'h08000000, 32'h010061B2,
      32'h01E0F401, 32'h00000002, 32'h010061B0};

   // Values the controller must load after every power cycle.
   localparam rfc_word_t RFC_INIT_CFG_ONE = 32'hBEA41603;
   localparam rfc_word_t RFC_INIT_TEST_TWO = 32'h00C00002;
   localparam int RFC_FIX_LSB = 22;

   // ==========================================================
   // Field positions
   localparam int RFC_AMP_PATH_LSB = 4;
   localparam int RFC_BAND_BIT = 1;
   localparam int RFC_INT_MODE_BIT = 3;
   localparam int RFC_REF_DIV_LSB = 3;
   localparam int RFC_REF_DIV_W = 10;
   localparam int RFC_MONITOR_BIT = 0;
   localparam int RFC_Q_ENABLE_BIT = 1;
   localparam int RFC_EXT_CLK_BIT = 0;

   localparam logic [1:0] RFC_AMP_HIGH = 2'h0;
   localparam logic [1:0] RFC_AMP_LOW = 2'h1;

   // ==========================================================
   // Controller register map (byte addresses) and bits
   localparam logic [7:0] RFC_CTL_CMD = 8'h00;
   localparam logic [7:0] RFC_CTL_WDATA = 8'h04;
   localparam logic [7:0] RFC_CTL_RDATA = 8'h08;
   localparam logic [7:0] RFC_CTL_STATUS = 8'h0C;
   localparam logic [7:0] RFC_CTL_IRQ_STAT = 8'h10;
   localparam logic [7:0] RFC_CTL_IRQ_MASK = 8'h14;
   localparam logic [7:0] RFC_CTL_DIV = 8'h18;
   localparam int RFC_CMD_RW_BIT = 4;
   localparam int RFC_CMD_GO_BIT = 8;
   localparam int RFC_EV_DONE = 0;
   localparam int RFC_EV_LOCK_LOST = 1;

   // ==========================================================
   // Timing
   localparam int RFC_MCLK_NS = 8;
   localparam int RFC_SCLK_MIN_PERIOD_NS = 128;
   localparam logic [7:0] RFC_HALF_CYCLES =
      8'((RFC_SCLK_MIN_PERIOD_NS + 2 * RFC_MCLK_NS - 1) / (2 * RFC_MCLK_NS));
endpackage

// ==== shared/rfc_link_if.sv ====
// Three-wire serial link between the controller and the configuration bank.
`timescale 1ns/1ps
`default_nettype none
interface rfc_link_if;
   logic sclk;
   logic device_select_n;
   logic host_io_out;
   logic host_io_oe;
   logic dev_io_out;
   logic dev_io_oe;
   logic serial_io_line;

   // ==========================================================
   // Wire resolution: a driver wins, an idle line floats high by pull-up.
   assign serial_io_line = host_io_oe ? host_io_out : (dev_io_oe ? dev_io_out : 1'b1);

   modport host (output sclk, output device_select_n, output host_io_out, output host_io_oe,
                 input serial_io_line);
   modport device (input sclk, input device_select_n, input serial_io_line,
                   output dev_io_out, output dev_io_oe);
endinterface
`default_nettype wire

// ==== core/rfc_device.sv ====
// Receiver configuration bank: serial slave, register file and digital control pins.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module rfc_device
   import rfc_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   rfc_link_if.device link,
   input wire logic power_off_n,
   input wire logic synth_locked,
   input wire logic converter_clock_in,
   input wire logic [1:0] i_sample,
   input wire logic [1:0] q_sample,
   output logic loop_locked_flag,
   output logic tuning_band_select,
   output logic analog_monitor_enable,
   output logic [1:0] amp_path_select,
   output logic high_amp_on,
   output logic low_amp_on,
   output logic synth_integer_mode,
   output logic [RFC_REF_DIV_W-1:0] synth_ref_div,
   output logic converter_clock_external,
   output logic inphase_bit_zero,
   output logic inphase_bit_one,
   output logic quadrature_bit_zero,
   output logic quadrature_bit_one,
   output logic monitor_out_pos,
   output logic monitor_out_neg
);
   // ==========================================================
   // Input synchronisers
   // Every pin from outside except i_sample and q_sample passes two flops; only the second stage is read.
   localparam int NSYNC = 6;
   localparam logic [NSYNC-1:0] SYNC_RST = 6'h02;
   logic [NSYNC-1:0] meta_q;
   logic [NSYNC-1:0] sync_q;
   logic sclk_prev_q;
   logic sel_prev_q;
   logic cclk_prev_q;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_q <= SYNC_RST;
         sync_q <= SYNC_RST;
         sclk_prev_q <= 1'b0;
         sel_prev_q <= 1'b1;
         cclk_prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= {converter_clock_in, synth_locked, power_off_n, link.serial_io_line,
                    link.device_select_n, link.sclk};
         sync_q <= meta_q;
         sclk_prev_q <= sync_q[0];
         sel_prev_q <= sync_q[1];
         cclk_prev_q <= sync_q[5];
      end
   end

   // Edge detection on the synchronised link pins.
   wire sclk_s = sync_q[0];
   wire sel_n_s = sync_q[1];
   wire io_s = sync_q[2];
   wire powered = sync_q[3];
   wire locked_s = sync_q[4];
   wire cclk_s = sync_q[5];
   wire selected = powered & ~sel_n_s;
   wire sclk_rise = selected & sclk_s & ~sclk_prev_q;
   wire sclk_fall = selected & ~sclk_s & sclk_prev_q;
   wire sel_rise = sel_n_s & ~sel_prev_q;

   // ==========================================================
   // Serial engine
   logic [RFC_FRAME_BITS-1:0] in_q;
   logic [RFC_CNT_W-1:0] cnt_q;
   logic [RFC_DATA_W-1:0] out_q;
   logic io_out_q;
   logic io_oe_q;
   rfc_word_t cfg_q [RFC_NUM_REGS];

   // Reads of unmapped addresses return zero.
   function automatic rfc_word_t reg_read(input logic [RFC_ADDR_W-1:0] a);
      reg_read = (32'(a) < RFC_NUM_REGS) ? cfg_q[a] : 32'h00000000;
   endfunction

   wire [RFC_ADDR_W-1:0] hdr_addr = in_q[RFC_ADDR_W:1];
   wire hdr_read = in_q[0];
   wire rd_turn = sclk_fall & (cnt_q == RFC_CNT_W'(RFC_HDR_BITS)) & hdr_read;
   wire rfc_word_t rd_word = reg_read(hdr_addr);
   wire [RFC_ADDR_W-1:0] fr_addr = in_q[RFC_FRAME_BITS-1:RFC_DATA_W+1];
   wire fr_write = ~in_q[RFC_DATA_W];
   wire frame_full = (cnt_q == RFC_CNT_W'(RFC_FRAME_BITS));
   wire commit = sel_rise & powered & frame_full & fr_write;

   // Bits enter on rising edges of the serial clock, MSB first.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         in_q <= '0;
         cnt_q <= '0;
      end
      else if (sel_rise | ~powered)
      begin
         cnt_q <= '0;
      end
      else if (sclk_rise & ~frame_full)
      begin
         in_q <= {in_q[RFC_FRAME_BITS-2:0], io_s};
         cnt_q <= cnt_q + RFC_CNT_W'(1);
      end
   end

   // Readback shifts out on falling edges once the header asks for a read.
   // The line is released once the synchronised select is high, so the host can retake it.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         out_q <= '0;
         io_out_q <= 1'b0;
         io_oe_q <= 1'b0;
      end
      else if (~selected)
      begin
         io_oe_q <= 1'b0;
      end
      else if (rd_turn)
      begin
         io_oe_q <= 1'b1;
         io_out_q <= rd_word[RFC_DATA_W-1];
         out_q <= {rd_word[RFC_DATA_W-2:0], 1'b0};
      end
      else if (sclk_fall & io_oe_q)
      begin
         io_out_q <= out_q[RFC_DATA_W-1];
         out_q <= {out_q[RFC_DATA_W-2:0], 1'b0};
      end
   end

   assign link.dev_io_out = io_out_q;
   assign link.dev_io_oe = io_oe_q;

   // ==========================================================
   // Register file
   // A complete write frame commits when select returns high; short frames are dropped.
   genvar g;
   generate
      for (g = 0; g < RFC_NUM_REGS; g++)
      begin : g_reg
         always_ff @(posedge mclk or negedge resetn)
         begin
            if (!resetn)
               cfg_q[g] <= RFC_RESET[g];
            else if (commit && fr_addr == RFC_ADDR_W'(g))
               cfg_q[g] <= in_q[RFC_DATA_W-1:0];
         end
      end
   endgenerate

   // ==========================================================
   // Control decode
   wire rfc_word_t cfg_one = cfg_q[RFC_IDX_CFG_ONE];
   wire rfc_word_t synth_cfg = cfg_q[RFC_IDX_SYNTH_CFG];
   wire rfc_word_t sample_cfg = cfg_q[RFC_IDX_SAMPLE_PORT];
   wire [1:0] amp_code = cfg_one[RFC_AMP_PATH_LSB +: 2];
   wire amp_hi_d = powered & (amp_code == RFC_AMP_HIGH);
   wire amp_lo_d = powered & (amp_code == RFC_AMP_LOW);
   wire band_d = synth_cfg[RFC_BAND_BIT];
   wire mon_d = powered & sample_cfg[RFC_MONITOR_BIT];
   wire q_en_d = sample_cfg[RFC_Q_ENABLE_BIT];
   wire ext_clk_d = cfg_q[RFC_IDX_CLOCKING_ONE][RFC_EXT_CLK_BIT];
   // Samples advance on every internal clock or on each synchronised rising external edge.
   wire sample_tick = ext_clk_d ? (cclk_s & ~cclk_prev_q) : 1'b1;

   // ==========================================================
   // Registered pins
   // Shutdown forces every pin low; the register contents survive it.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         loop_locked_flag <= 1'b0;
         tuning_band_select <= 1'b0;
         analog_monitor_enable <= 1'b0;
         amp_path_select <= 2'h0;
         high_amp_on <= 1'b0;
         low_amp_on <= 1'b0;
         synth_integer_mode <= 1'b0;
         synth_ref_div <= '0;
         converter_clock_external <= 1'b0;
      end
      else
      begin
         loop_locked_flag <= powered & locked_s;
         tuning_band_select <= powered & band_d;
         analog_monitor_enable <= mon_d;
         amp_path_select <= powered ? amp_code : 2'h0;
         high_amp_on <= amp_hi_d;
         low_amp_on <= amp_lo_d;
         synth_integer_mode <= powered & synth_cfg[RFC_INT_MODE_BIT];
         synth_ref_div <= powered ? cfg_q[RFC_IDX_SYNTH_INT][RFC_REF_DIV_LSB +: RFC_REF_DIV_W]
                                  : '0;
         converter_clock_external <= powered & ext_clk_d;
      end
   end

   // Sample pins: in-phase always, quadrature only when enabled.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         inphase_bit_zero <= 1'b0;
         inphase_bit_one <= 1'b0;
         quadrature_bit_zero <= 1'b0;
         quadrature_bit_one <= 1'b0;
         monitor_out_pos <= 1'b0;
         monitor_out_neg <= 1'b0;
      end
      else if (~powered)
      begin
         inphase_bit_zero <= 1'b0;
         inphase_bit_one <= 1'b0;
         quadrature_bit_zero <= 1'b0;
         quadrature_bit_one <= 1'b0;
         monitor_out_pos <= 1'b0;
         monitor_out_neg <= 1'b0;
      end
      else if (sample_tick)
      begin
         inphase_bit_zero <= i_sample[0];
         inphase_bit_one <= i_sample[1];
         quadrature_bit_zero <= q_en_d & q_sample[0];
         quadrature_bit_one <= q_en_d & q_sample[1];
         monitor_out_pos <= mon_d & i_sample[1];
         monitor_out_neg <= mon_d & ~i_sample[1];
      end
   end
endmodule // rfc_device
`default_nettype wire

// ==== core/rfc_host.sv ====
// Serial controller: software registers in, three-wire frames out, init writes after reset.
`timescale 1ns/1ps
`default_nettype none
module rfc_host
   import rfc_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   rfc_link_if.host link,
   input wire logic loop_locked_flag,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic irq
);
   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} rfc_hstate_t;

   // ==========================================================
   // Synchronisers for the shared data line and the lock pin
   logic [1:0] meta_q;
   logic [1:0] sync_q;
   logic lock_prev_q;
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_q <= 2'h0;
         sync_q <= 2'h0;
         lock_prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= {loop_locked_flag, link.serial_io_line};
         sync_q <= meta_q;
         lock_prev_q <= sync_q[1];
      end
   end

   // ==========================================================
   // Software registers
   rfc_hstate_t st_q;
   logic [RFC_ADDR_W:0] cmd_q;
   logic [31:0] wd_q;
   logic [31:0] rx_q;
   logic [1:0] stat_q;
   logic [1:0] mask_q;
   logic [7:0] div_q;
   logic [1:0] init_q;
   logic done_q;
   logic [RFC_FRAME_BITS-1:0] tx_q;
   logic [RFC_CNT_W-1:0] bit_q;
   logic [7:0] tick_q;

   wire busy = (st_q != H_IDLE) | (init_q != 2'h0);
   wire wr_cmd = wr & (addr == RFC_CTL_CMD);
   wire go = wr_cmd & wdata[RFC_CMD_GO_BIT] & ~busy;
   wire [1:0] events = {lock_prev_q & ~sync_q[1], done_q};
   wire [31:0] status = {29'h0, sync_q[1], init_q != 2'h0, busy};
   wire [31:0] rd_mux = (addr == RFC_CTL_CMD) ? {27'h0, cmd_q} :
                        (addr == RFC_CTL_WDATA) ? wd_q :
                        (addr == RFC_CTL_RDATA) ? rx_q :
                        (addr == RFC_CTL_STATUS) ? status :
                        (addr == RFC_CTL_IRQ_STAT) ? {30'h0, stat_q} :
                        (addr == RFC_CTL_IRQ_MASK) ? {30'h0, mask_q} :
                        (addr == RFC_CTL_DIV) ? {24'h0, div_q} : 32'h00000000;

   // Sticky events: a new event in the clearing cycle stays set.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cmd_q <= '0;
         wd_q <= '0;
         mask_q <= 2'h0;
         div_q <= RFC_HALF_CYCLES;
         stat_q <= 2'h0;
         rdata <= '0;
      end
      else
      begin
         if (wr_cmd & ~busy)
            cmd_q <= wdata[RFC_ADDR_W:0];
         if (wr & (addr == RFC_CTL_WDATA) & ~busy)
            wd_q <= wdata;
         if (wr & (addr == RFC_CTL_IRQ_MASK))
            mask_q <= wdata[1:0];
         if (wr & (addr == RFC_CTL_DIV) & ~busy)
            div_q <= (wdata[7:0] < RFC_HALF_CYCLES) ? RFC_HALF_CYCLES : wdata[7:0];
         stat_q <= (stat_q & ~((wr & (addr == RFC_CTL_IRQ_STAT)) ? wdata[1:0] : 2'h0)) | events;
         rdata <= rd ? rd_mux : 32'h00000000;
      end
   end

   assign irq = |(stat_q & mask_q);

   // ==========================================================
   // Frame engine
   // Two writes of the fixed reserved patterns go out before software may start frames.
   wire half_done = (tick_q == div_q - 8'h01);
   wire last_bit = (bit_q == RFC_CNT_W'(RFC_FRAME_BITS - 1));
   // Select stays high through the gap state so the bank sees every frame end.
   wire link_idle = (st_q == H_IDLE) | (st_q == H_GAP);
   logic rd_cur_q;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q <= H_IDLE;
         init_q <= 2'h3;
         tx_q <= '0;
         bit_q <= '0;
         tick_q <= '0;
         done_q <= 1'b0;
         rx_q <= '0;
         rd_cur_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         tick_q <= (st_q == H_IDLE || half_done) ? 8'h00 : tick_q + 8'h01;
         unique case (st_q)
            H_IDLE:
            begin
               bit_q <= '0;
               if (init_q[1])
               begin
                  tx_q <= {RFC_IDX_CFG_ONE, 1'b0, RFC_INIT_CFG_ONE};
                  st_q <= H_SETUP;
               end
               else if (init_q[0])
               begin
                  tx_q <= {RFC_IDX_TEST_TWO, 1'b0, RFC_INIT_TEST_TWO};
                  st_q <= H_SETUP;
               end
               else if (go)
               begin
                  tx_q <= {wdata[RFC_ADDR_W-1:0], wdata[RFC_CMD_RW_BIT], wd_q};
                  rd_cur_q <= wdata[RFC_CMD_RW_BIT];
                  st_q <= H_SETUP;
               end
            end
            H_SETUP:
               if (half_done)
                  st_q <= H_LOW;
            H_LOW:
               if (half_done)
                  st_q <= H_HIGH;
            H_HIGH:
               if (half_done)
               begin
                  rx_q <= rd_cur_q ? {rx_q[30:0], sync_q[0]} : rx_q;
                  tx_q <= {tx_q[RFC_FRAME_BITS-2:0], 1'b0};
                  bit_q <= bit_q + RFC_CNT_W'(1);
                  st_q <= last_bit ? H_HOLD : H_LOW;
               end
            H_HOLD:
               if (half_done)
                  st_q <= H_GAP;
            H_GAP:
               if (half_done)
               begin
                  st_q <= H_IDLE;
                  init_q <= {1'b0, init_q[1] & init_q[0]};
                  done_q <= (init_q == 2'h0);
                  rd_cur_q <= 1'b0;
               end
         endcase
      end
   end

   // The data line is released after the header of a read so the bank can answer.
   assign link.sclk = (st_q == H_HIGH);
   assign link.device_select_n = link_idle;
   assign link.host_io_out = tx_q[RFC_FRAME_BITS-1];
   assign link.host_io_oe = ~link_idle & ~(rd_cur_q & (bit_q >= RFC_CNT_W'(RFC_HDR_BITS)));
endmodule // rfc_host
`default_nettype wire

// ==== test/rfc_link_sva.sv ====
// Protocol checker for the three-wire link between controller and bank.
`timescale 1ns/1ps
`default_nettype none
module rfc_link_sva (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic sclk,
   input wire logic device_select_n,
   input wire logic host_io_out,
   input wire logic host_io_oe,
   input wire logic dev_io_out,
   input wire logic dev_io_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic sclk_q;
   logic [5:0] rise_cnt_q;
   // ==========================================================
   // Helper logic
   // Counts clock rises per frame; cleared while deselected so a short frame shows.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         sclk_q <= 1'b0;
         rise_cnt_q <= 6'h00;
      end
      else
      begin
         sclk_q <= sclk;
         rise_cnt_q <= device_select_n ? 6'h00 : rise_cnt_q + {5'h00, sclk & ~sclk_q};
      end
   end
   // ==========================================================
   // Properties
   property p_no_fight; !(host_io_oe && dev_io_oe); endproperty
   property p_sclk_idle; device_select_n |-> !sclk; endproperty
   property p_host_oe_sel; host_io_oe |-> !device_select_n; endproperty
   // The bank sees select through two flops, so it lets go three cycles after select rises.
   property p_dev_oe_sel; device_select_n && $past(device_select_n, 3) |-> !dev_io_oe; endproperty
   property p_host_hold; sclk && $past(sclk) && host_io_oe && $past(host_io_oe) |-> $stable(host_io_out); endproperty
   property p_dev_hold; sclk && $past(sclk) && dev_io_oe && $past(dev_io_oe) |-> $stable(dev_io_out); endproperty
   property p_dev_on_low; $rose(dev_io_oe) |-> !sclk; endproperty
   property p_high_phase; $rose(sclk) |-> sclk [*8]; endproperty
   property p_sel_gap; $rose(device_select_n) |-> device_select_n [*8]; endproperty
   property p_frame_len; $rose(device_select_n) |-> rise_cnt_q == 6'h25; endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("both ends drive the data line");
   a_sclk_idle: assert property (p_sclk_idle)
      else $error("serial clock high while deselected");
   a_host_oe_sel: assert property (p_host_oe_sel)
      else $error("controller drives line while deselected");
   a_dev_oe_sel: assert property (p_dev_oe_sel)
      else $error("bank drives line while deselected");
   a_host_hold: assert property (p_host_hold)
      else $error("controller data moved during clock high");
   a_dev_hold: assert property (p_dev_hold)
      else $error("bank data moved during clock high");
   a_dev_on_low: assert property (p_dev_on_low)
      else $error("bank took the line while clock high");
   a_high_phase: assert property (p_high_phase)
      else $error("clock high phase shorter than eight cycles");
   a_sel_gap: assert property (p_sel_gap)
      else $error("select gap between frames too short");
   a_frame_len: assert property (p_frame_len)
      else $error("frame did not carry thirty-seven bits");
   c_frame: cover property ($rose(device_select_n) && rise_cnt_q == 6'h25);
   c_read: cover property ($rose(dev_io_oe));
   c_start: cover property ($fell(device_select_n));
endmodule // rfc_link_sva
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench: controller and configuration bank joined over the link.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import rfc_pkg::*;
;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic power_off_n = 1'b1;
   logic synth_locked = 1'b0;
   logic conv_clk = 1'b0;
   logic [1:0] i_sample = 2'h2;
   logic [1:0] q_sample = 2'h3;
   logic [31:0] rdata, got;
   logic irq, locked, band, mon_en, high_on, low_on, int_mode, ext_clk, ib0, ib1, qb0, qb1, mp, mn;
   logic [1:0] amp;
   logic [9:0] ref_div;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   // Expected contents once the two start-up writes have landed.
   rfc_word_t dflt [11] = '{32'hBEA41603, 32'h20550288, 32'h0EAFA1DC, 32'h698C0008, 32'h00C00080,
      32'h08000070, 32'h08000000, 32'h010061B2, 32'h01E0F401, 32'h00C00002, 32'h010061B0};
   rfc_link_if link ();
   rfc_host rfc_host_i (.mclk(mclk), .resetn(resetn), .link(link), .loop_locked_flag(locked), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
   rfc_device rfc_device_i (.mclk(mclk), .resetn(resetn), .link(link), .power_off_n(power_off_n),
      .synth_locked(synth_locked), .converter_clock_in(conv_clk), .i_sample(i_sample), .q_sample(q_sample),
      .loop_locked_flag(locked), .tuning_band_select(band), .analog_monitor_enable(mon_en),
      .amp_path_select(amp), .high_amp_on(high_on), .low_amp_on(low_on), .synth_integer_mode(int_mode),
      .synth_ref_div(ref_div), .converter_clock_external(ext_clk), .inphase_bit_zero(ib0),
      .inphase_bit_one(ib1), .quadrature_bit_zero(qb0), .quadrature_bit_one(qb1), .monitor_out_pos(mp),
      .monitor_out_neg(mn));
   rfc_link_sva rfc_link_sva_i (.mclk(mclk), .resetn(resetn), .sclk(link.sclk),
      .device_select_n(link.device_select_n), .host_io_out(link.host_io_out), .host_io_oe(link.host_io_oe),
      .dev_io_out(link.dev_io_out), .dev_io_oe(link.dev_io_oe));
   // ==========================================================
   // Clock, hang guard and shared tasks
   always #4 mclk = ~mclk;
   // A hung frame would stall the sequence forever, so cycles are capped.
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         bad_count++;
         finish_test();
      end
   end
   task automatic finish_test;
      if (bad_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] act);
      compares++;
      if (exp !== act)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, act);
      end
   endtask
   task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe.
   task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic wait_idle;
      logic [31:0] s;
      int n;
      s = 32'h00000001;
      n = 0;
      while (s[0] !== 1'b0 && n < 3000)
      begin
         sw_rd(RFC_CTL_STATUS, s);
         n++;
      end
      check("busy", 32'h0, {31'h0, s[0]});
      repeat (8) @(posedge mclk);
   endtask
   task automatic lwr(input logic [3:0] r, input logic [31:0] d);
      sw_wr(RFC_CTL_WDATA, d);
      sw_wr(RFC_CTL_CMD, {23'h0, 1'b1, 3'h0, 1'b0, r});
      wait_idle();
   endtask
   task automatic lrd(input logic [3:0] r, output logic [31:0] d);
      sw_wr(RFC_CTL_CMD, {23'h0, 1'b1, 3'h0, 1'b1, r});
      wait_idle();
      sw_rd(RFC_CTL_RDATA, d);
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      wait_idle();
      for (int r = 0; r < 11; r++)
      begin
         lrd(4'(r), got);
         check("reg", dflt[r], got);
      end
      check("synth", {1'b1, 10'h010, 1'b0}, {int_mode, ref_div, band});
      check("pins", {1'b0, 2'h2, 2'h0}, {mon_en, ib1, ib0, qb1, qb0});
      for (int k = 0; k < 3; k++)
      begin
         lwr(4'h0, 32'hBEA41603 | (32'(k) << 4));
         check("amp", {2'(k), k == 0, k == 1}, {amp, high_on, low_on});
      end
      lwr(4'h3, 32'h698C000A);
      lrd(4'h3, got);
      check("band", 32'h1, {31'h0, band});
      check("reg3", 32'h698C000A, got);
      lwr(4'hB, 32'h12345678);
      lrd(4'hB, got);
      check("reg_b", 32'h0, got);
      sw_rd(8'h1C, got);
      check("unmapped", 32'h0, got);
      lwr(4'h6, 32'h08000003);
      check("monitor", {1'b1, 2'h3, 1'b1, 1'b0}, {mon_en, qb1, qb0, mp, mn});
      lwr(4'h7, 32'h010061B3);
      i_sample <= 2'h1;
      repeat (10) @(posedge mclk);
      check("ext_hold", {1'b1, 2'h2}, {ext_clk, ib1, ib0});
      conv_clk <= 1'b1;
      repeat (8) @(posedge mclk);
      check("ext_step", 2'h1, {ib1, ib0});
      conv_clk <= 1'b0;
      sw_wr(RFC_CTL_IRQ_MASK, 32'h2);
      sw_wr(RFC_CTL_IRQ_STAT, 32'h3);
      synth_locked <= 1'b1;
      repeat (8) @(posedge mclk);
      check("locked", 2'h2, {locked, irq});
      synth_locked <= 1'b0;
      repeat (8) @(posedge mclk);
      sw_rd(RFC_CTL_IRQ_STAT, got);
      check("lost", 3'h6, {got[1], irq, locked});
      sw_wr(RFC_CTL_IRQ_MASK, 32'h0);
      sw_rd(RFC_CTL_IRQ_STAT, got);
      check("masked", 2'h2, {got[1], irq});
      sw_wr(RFC_CTL_IRQ_MASK, 32'h2);
      sw_wr(RFC_CTL_IRQ_STAT, 32'h2);
      sw_rd(RFC_CTL_IRQ_STAT, got);
      check("cleared", 2'h0, {got[1], irq});
      power_off_n <= 1'b0;
      repeat (10) @(posedge mclk);
      check("off", 4'h0, {ib0, ext_clk, mon_en, qb1});
      power_off_n <= 1'b1;
      repeat (10) @(posedge mclk);
      check("on", 2'h3, {ext_clk, mon_en});
      finish_test();
   end
endmodule // testbench
`default_nettype wire
